// ### design/protect_irq_pkg.sv
/*
  Constants for the link protection status and interrupt enable registers.
  Assumes one clock domain and byte-wide registers behind the serial control bus.
*/
package protect_irq_pkg;
  localparam logic [7:0] status_offset      = 8'hc4;
  localparam logic [7:0] irq_enable_offset  = 8'hc6;
  localparam logic [7:0] status_reset       = 8'h00;
  localparam logic [7:0] irq_enable_reset   = 8'h00;
  localparam logic [7:0] unmapped_read_data = 8'h00;
  // Status field positions
  localparam int st_chan_err  = 7;
  localparam int st_far_irq   = 6;
  localparam int st_far_lock  = 5;
  localparam int st_down_plug = 4;
  localparam int st_presence  = 3;
  localparam int st_list_rdy  = 2;
  localparam int st_key_rdy   = 1;
  localparam int st_auth_ok   = 0;
  // Enable and pending field positions
  localparam int ie_indirect  = 7;
  localparam int ie_presence  = 6;
  localparam int ie_far_irq   = 5;
  localparam int list_ready_irq_enable  = 4;
  localparam int ie_key_rdy   = 3;
  localparam int ie_auth_fail = 2;
  localparam int auth_pass_irq_enable = 1;
  localparam int ie_global    = 0;
  localparam int sync_stages  = 2;
endpackage : protect_irq_pkg

// ### design/level_sync.sv
/*
  Two flip-flop synchroniser for a group of levels.
  Assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int width = 3
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [width-1:0] async_in,
  input  wire logic [width-1:0] rst_val,
  output logic      [width-1:0] sync_out
);
  typedef struct packed {
    logic [width-1:0] meta;
    logic [width-1:0] sync;
  } sync_state_t;

  sync_state_t sy_r;
  sync_state_t sy_nxt;

  // First stage feeds only the second stage
  always_comb begin
    sy_nxt      = sy_r;
    sy_nxt.meta = async_in;
    sy_nxt.sync = sy_r.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sy_r <= {rst_val, rst_val};
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign sync_out = sy_r.sync;
endmodule : level_sync

// ### design/link_protect_status_irq.sv
/*
  Link protection status register, interrupt enable register and interrupt line.
  Assumes the serial control bus slave drives the byte port on clk, and that
  event inputs are one-cycle pulses from logic on clk. Link-side levels are
  asynchronous and pass a synchroniser.
*/
`timescale 1ns/1ps
module link_protect_status_irq (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       chan_error_evt,
  input  wire logic       down_plug_evt,
  input  wire logic       list_loaded_evt,
  input  wire logic       key_loaded_evt,
  input  wire logic       key_list_accept,
  input  wire logic       key_accept,
  input  wire logic       auth_pass_evt,
  input  wire logic       auth_fail_evt,
  input  wire logic       auth_restart,
  input  wire logic       indirect_done_evt,
  input  wire logic       pending_ack,
  input  wire logic       detect_needs_lock,
  input  wire logic       far_irq_input_n,
  input  wire logic       far_lock_in,
  input  wire logic       presence_in,
  output logic      [7:0] irq_pending,
  output logic            irq_n
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       chan_err;
    logic       down_plug;
    logic       list_rdy;
    logic       key_rdy;
    logic       auth_ok;
    logic       indirect_hit;
    logic       fail_hit;
    logic [7:0] irq_enable;
    logic [7:0] rdata;
    logic [7:0] pending;
    logic       irq_n;
  } state_t;

  state_t     st_r;
  state_t     st_nxt;
  logic [2:0] link_s;
  logic       far_irq_s_n;
  logic       far_lock_s;
  logic       presence_s;
  logic [7:0] status_now;
  logic [7:0] source_now;
  logic       rd_status;
  logic       wr_enable;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    hit = (addr == offs);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Far interrupt resets high so no false interrupt during reset
  level_sync #(.width(3)) u_link_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({far_irq_input_n, far_lock_in, presence_in}),
    .rst_val  (3'h4),
    .sync_out (link_s)
  );
  assign far_irq_s_n = link_s[2];
  assign far_lock_s  = link_s[1];
  assign presence_s  = link_s[0];

  assign rd_status = reg_rd && hit(reg_addr, protect_irq_pkg::status_offset);
  assign wr_enable = reg_wr && hit(reg_addr, protect_irq_pkg::irq_enable_offset);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status_now = protect_irq_pkg::status_reset;
    status_now[protect_irq_pkg::st_chan_err]  = st_r.chan_err;
    status_now[protect_irq_pkg::st_far_irq]   = far_irq_s_n;
    status_now[protect_irq_pkg::st_far_lock]  = far_lock_s;
    status_now[protect_irq_pkg::st_down_plug] = st_r.down_plug;
    status_now[protect_irq_pkg::st_presence]  = presence_s;
    status_now[protect_irq_pkg::st_list_rdy]  = st_r.list_rdy;
    status_now[protect_irq_pkg::st_key_rdy]   = st_r.key_rdy;
    status_now[protect_irq_pkg::st_auth_ok]   = st_r.auth_ok;

    source_now = 8'h00;
    source_now[protect_irq_pkg::ie_indirect]  = st_r.indirect_hit;
    source_now[protect_irq_pkg::ie_presence]  = presence_s && (!detect_needs_lock || far_lock_s);
    source_now[protect_irq_pkg::ie_far_irq]   = !far_irq_s_n;
    source_now[protect_irq_pkg::list_ready_irq_enable]  = st_r.list_rdy;
    source_now[protect_irq_pkg::ie_key_rdy]   = st_r.key_rdy;
    source_now[protect_irq_pkg::ie_auth_fail] = st_r.fail_hit;
    source_now[protect_irq_pkg::auth_pass_irq_enable] = st_r.auth_ok;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    // Set terms come last, except for auth_ok, so a same-cycle event wins over a clear
    if (rd_status) begin
      st_nxt.chan_err  = 1'b0;
      st_nxt.down_plug = 1'b0;
    end
    if (chan_error_evt) begin
      st_nxt.chan_err = 1'b1;
    end
    if (down_plug_evt) begin
      st_nxt.down_plug = 1'b1;
    end
    if (key_list_accept) begin
      st_nxt.list_rdy = 1'b0;
    end
    if (list_loaded_evt) begin
      st_nxt.list_rdy = 1'b1;
    end
    if (key_accept) begin
      st_nxt.key_rdy = 1'b0;
    end
    if (key_loaded_evt) begin
      st_nxt.key_rdy = 1'b1;
    end
    // Loss, failure and restart all drop the authenticated state
    if (auth_pass_evt) begin
      st_nxt.auth_ok = 1'b1;
    end
    if (auth_fail_evt || auth_restart) begin
      st_nxt.auth_ok = 1'b0;
    end
    if (pending_ack) begin
      st_nxt.indirect_hit = 1'b0;
      st_nxt.fail_hit     = 1'b0;
    end
    if (indirect_done_evt) begin
      st_nxt.indirect_hit = 1'b1;
    end
    // Loss of an established session counts as failure
    if (auth_fail_evt) begin
      st_nxt.fail_hit = 1'b1;
    end
    if (wr_enable) begin
      st_nxt.irq_enable = reg_wdata;
    end
    if (reg_rd) begin
      if (hit(reg_addr, protect_irq_pkg::status_offset)) begin
        st_nxt.rdata = status_now;
      end else if (hit(reg_addr, protect_irq_pkg::irq_enable_offset)) begin
        st_nxt.rdata = st_r.irq_enable;
      end else begin
        st_nxt.rdata = protect_irq_pkg::unmapped_read_data;
      end
    end
    st_nxt.pending[7:1] = source_now[7:1] & st_r.irq_enable[7:1];
    st_nxt.pending[0]   = |(source_now[7:1] & st_r.irq_enable[7:1]);
    // Line lags pending by one flop stage; both stay registered
    st_nxt.irq_n = !(st_r.pending[0] && st_r.irq_enable[protect_irq_pkg::ie_global]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r            <= '0;
      st_r.irq_enable <= protect_irq_pkg::irq_enable_reset;
      st_r.irq_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata   = st_r.rdata;
  assign irq_pending = st_r.pending;
  assign irq_n       = st_r.irq_n;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Clear-on-read flags read with or without an event in the read cycle
  sequence err_on_read_s;
    chan_error_evt && rd_status;
  endsequence
  sequence plug_on_read_s;
    down_plug_evt && rd_status;
  endsequence
  sequence plug_read_s;
    rd_status && !down_plug_evt;
  endsequence

  // Handshake flags hold until the host accepts
  sequence list_accept_s;
    key_list_accept && !list_loaded_evt;
  endsequence
  sequence key_accept_s;
    key_accept && !key_loaded_evt;
  endsequence

  // A drop outranks a pass; an ack loses to a new event
  sequence auth_pass_only_s;
    auth_pass_evt && !auth_fail_evt && !auth_restart;
  endsequence
  sequence ack_only_s;
    pending_ack && !indirect_done_evt && !auth_fail_evt;
  endsequence

  // Source, then pending, then the line: two flop stages
  sequence any_enabled_s;
    (source_now[7:1] & st_r.irq_enable[7:1]) != 7'h00;
  endsequence
  sequence line_due_s;
    st_r.pending[protect_irq_pkg::ie_global] && st_r.irq_enable[protect_irq_pkg::ie_global];
  endsequence

  err_kept_a: assert property (err_on_read_s
    |=> st_r.chan_err && reg_rdata[protect_irq_pkg::st_chan_err] == $past(st_r.chan_err))
    else $error("channel error lost on read");
  err_set_a: assert property (chan_error_evt |=> st_r.chan_err)
    else $error("channel error not set");
  err_clear_a: assert property (rd_status && !chan_error_evt |=> !st_r.chan_err)
    else $error("channel error not cleared by read");
  plug_kept_a: assert property (plug_on_read_s
    |=> st_r.down_plug && reg_rdata[protect_irq_pkg::st_down_plug] == $past(st_r.down_plug))
    else $error("plug flag lost on read");
  plug_set_a: assert property (down_plug_evt |=> st_r.down_plug)
    else $error("plug flag not set");
  plug_clear_a: assert property (plug_read_s |=> !st_r.down_plug)
    else $error("plug flag not cleared by read");
  far_mirror_a: assert property (rd_status
    |=> reg_rdata[protect_irq_pkg::st_far_irq] == $past(far_irq_s_n))
    else $error("far interrupt not mirrored");
  lock_mirror_a: assert property (rd_status
    |=> reg_rdata[protect_irq_pkg::st_far_lock] == $past(far_lock_s)
        && reg_rdata[protect_irq_pkg::st_presence] == $past(presence_s))
    else $error("lock or presence not shown");

  list_flag_a: assert property (list_loaded_evt |=> st_r.list_rdy)
    else $error("list ready not set");
  list_clear_a: assert property (list_accept_s |=> !st_r.list_rdy)
    else $error("list ready not cleared by accept");
  key_set_a: assert property (key_loaded_evt |=> st_r.key_rdy)
    else $error("key ready not set");
  key_clear_a: assert property (key_accept_s |=> !st_r.key_rdy)
    else $error("key ready not cleared");
  auth_set_a: assert property (auth_pass_only_s |=> st_r.auth_ok)
    else $error("authenticated not set on pass");
  auth_drop_a: assert property (auth_restart |=> !st_r.auth_ok)
    else $error("authenticated not cleared on restart");
  auth_fail_a: assert property (auth_fail_evt |=> !st_r.auth_ok && st_r.fail_hit)
    else $error("failure did not drop authentication");
  indirect_set_a: assert property (indirect_done_evt |=> st_r.indirect_hit)
    else $error("indirect done not held");
  ack_clear_a: assert property (ack_only_s |=> !st_r.indirect_hit && !st_r.fail_hit)
    else $error("sticky sources not cleared by ack");
  enable_write_a: assert property (wr_enable |=> st_r.irq_enable == $past(reg_wdata))
    else $error("enable register not written");
  enable_read_a: assert property (reg_rd && hit(reg_addr, protect_irq_pkg::irq_enable_offset)
    |=> reg_rdata == $past(st_r.irq_enable))
    else $error("enable register read wrong");
  unmapped_read_a: assert property (reg_rd && !rd_status && !hit(reg_addr, protect_irq_pkg::irq_enable_offset)
    |=> reg_rdata == protect_irq_pkg::unmapped_read_data)
    else $error("unmapped read not zero");

  indirect_pend_a: assert property (st_r.indirect_hit && st_r.irq_enable[protect_irq_pkg::ie_indirect]
    |=> irq_pending[protect_irq_pkg::ie_indirect])
    else $error("indirect done not pending");
  presence_gate_a: assert property (presence_s && detect_needs_lock && !far_lock_s
    |=> !irq_pending[protect_irq_pkg::ie_presence])
    else $error("presence interrupt ignored lock");
  presence_open_a: assert property (
    presence_s && !detect_needs_lock && st_r.irq_enable[protect_irq_pkg::ie_presence]
    |=> irq_pending[protect_irq_pkg::ie_presence])
    else $error("presence interrupt not pending");
  far_pend_a: assert property (!far_irq_s_n && st_r.irq_enable[protect_irq_pkg::ie_far_irq]
    |=> irq_pending[protect_irq_pkg::ie_far_irq])
    else $error("far interrupt not pending");
  far_quiet_a: assert property (far_irq_s_n |=> !irq_pending[protect_irq_pkg::ie_far_irq])
    else $error("far interrupt pending while idle");
  list_pend_a: assert property (st_r.list_rdy && st_r.irq_enable[protect_irq_pkg::list_ready_irq_enable]
    |=> irq_pending[protect_irq_pkg::list_ready_irq_enable])
    else $error("list ready not pending");
  key_pend_a: assert property (st_r.key_rdy && st_r.irq_enable[protect_irq_pkg::ie_key_rdy]
    |=> irq_pending[protect_irq_pkg::ie_key_rdy])
    else $error("key ready not pending");
  fail_pend_a: assert property (st_r.fail_hit && st_r.irq_enable[protect_irq_pkg::ie_auth_fail]
    |=> irq_pending[protect_irq_pkg::ie_auth_fail])
    else $error("failure not pending");
  pass_pend_a: assert property (st_r.auth_ok && st_r.irq_enable[protect_irq_pkg::auth_pass_irq_enable]
    |=> irq_pending[protect_irq_pkg::auth_pass_irq_enable])
    else $error("pass not pending");
  global_set_a: assert property (any_enabled_s |=> irq_pending[protect_irq_pkg::ie_global])
    else $error("global pending missed a source");
  global_clear_a: assert property ((source_now[7:1] & st_r.irq_enable[7:1]) == 7'h00
    |=> !irq_pending[protect_irq_pkg::ie_global])
    else $error("global pending without a source");
  global_gate_a: assert property (!st_r.irq_enable[protect_irq_pkg::ie_global] |=> irq_n)
    else $error("interrupt line active while globally disabled");
  line_follow_a: assert property (line_due_s |=> !irq_n)
    else $error("interrupt line missed pending source");
  src_line_a: assert property (any_enabled_s ##1 st_r.irq_enable[protect_irq_pkg::ie_global] |=> !irq_n)
    else $error("enabled source did not reach the line");
endmodule : link_protect_status_irq

// ### bench/host_model.sv
/*
  Host controller model on the byte register port.
  Assumes the block samples requests on the rising edge of clk.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  logic [7:0] exp_q[$];
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // Idle bus inverted, so a stale sample shows up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : host_model

// ### bench/link_protect_status_irq_tb.sv
/*
  Self-checking bench for the status and interrupt enable registers.
  Assumes host_model drives the register port; events come from here.
*/
`timescale 1ns/1ps
module link_protect_status_irq_tb;
  logic        clk, sys_rst, rd_d;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, irq_pending, rv, g;
  logic        reg_wr, reg_rd, irq_n, detect_needs_lock;
  logic        far_irq_input_n, far_lock_in, presence_in;
  logic [10:0] ev;
  int          n_mismatch, num_checks, k;
  // Order: key ready, list ready, auth pass, auth fail, indirect done
  localparam logic [10:0] set_m[5] = '{11'h008, 11'h004, 11'h040, 11'h080, 11'h200};
  localparam logic [10:0] clr_m[5] = '{11'h020, 11'h010, 11'h100, 11'h400, 11'h400};
  localparam logic [7:0]  ie_b[5]  = '{8'h08, 8'h10, 8'h02, 8'h04, 8'h80};
  localparam logic [7:0]  st_b[5]  = '{8'h02, 8'h04, 8'h01, 8'h00, 8'h00};
  host_model h (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  link_protect_status_irq dut (
    .clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .chan_error_evt(ev[0]), .down_plug_evt(ev[1]), .list_loaded_evt(ev[2]),
    .key_loaded_evt(ev[3]), .key_list_accept(ev[4]), .key_accept(ev[5]),
    .auth_pass_evt(ev[6]), .auth_fail_evt(ev[7]), .auth_restart(ev[8]),
    .indirect_done_evt(ev[9]), .pending_ack(ev[10]), .detect_needs_lock,
    .far_irq_input_n, .far_lock_in, .presence_in, .irq_pending, .irq_n);
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic irq(input logic [7:0] p, input logic n);
    check(irq_pending, p);
    check({7'h00, irq_n}, {7'h00, n});
  endtask : irq
  task automatic pulse(input logic [10:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 11'h000;
  endtask : pulse
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  // Read data is registered, so compare one edge after the strobe
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) check(reg_rdata, h.exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h1f1a));
    {clk, sys_rst, ev, detect_needs_lock} = {2'b01, 11'h000, 1'b0};
    {far_irq_input_n, far_lock_in, presence_in} = 3'b100;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    irq(8'h00, 1'b1);
    h.rd(8'hc4, 8'h40);
    h.rd(8'hc6, 8'h00);
    h.rd(8'hc5, 8'h00);
    rv = 8'($urandom);
    h.wr(8'hc6, rv);
    h.rd(8'hc6, rv);
    h.wr(8'hc4, 8'hff);
    h.rd(8'hc4, 8'h40);
    h.wr(8'hc6, 8'h00);
    pulse(11'h003);
    h.rd(8'hc4, 8'hd0);
    h.rd(8'hc4, 8'h40);
    fork
      h.rd(8'hc4, 8'h40);
      pulse(11'h003);
    join
    h.rd(8'hc4, 8'hd0);
    // Last pass repeats key ready with the global gate off
    for (int i = 0; i < 6; i++) begin
      g = (i < 5) ? 8'h01 : 8'h00;
      k = (i < 5) ? i : 0;
      h.wr(8'hc6, ie_b[k] | g);
      pulse(set_m[k]);
      repeat (3) @(negedge clk);
      irq(ie_b[k] | 8'h01, g == 8'h00);
      h.rd(8'hc4, 8'h40 | st_b[k]);
      pulse(clr_m[k]);
      repeat (3) @(negedge clk);
      irq(8'h00, 1'b1);
      h.rd(8'hc4, 8'h40);
    end
    // Pass, then pass and failure in one cycle: the drop wins
    h.wr(8'hc6, 8'h07);
    pulse(11'h040);
    repeat (3) @(negedge clk);
    irq(8'h03, 1'b0);
    pulse(11'h0c0);
    repeat (3) @(negedge clk);
    irq(8'h05, 1'b0);
    h.rd(8'hc4, 8'h40);
    pulse(11'h400);
    h.wr(8'hc6, 8'h61);
    far_irq_input_n = 1'b0;
    repeat (6) @(negedge clk);
    irq(8'h21, 1'b0);
    h.rd(8'hc4, 8'h00);
    far_irq_input_n = 1'b1;
    presence_in = 1'b1;
    repeat (6) @(negedge clk);
    irq(8'h41, 1'b0);
    detect_needs_lock = 1'b1;
    repeat (3) @(negedge clk);
    irq(8'h00, 1'b1);
    far_lock_in = 1'b1;
    repeat (6) @(negedge clk);
    irq(8'h41, 1'b0);
    h.rd(8'hc4, 8'h68);
    repeat (2) @(negedge clk);
    give_verdict();
  end
endmodule : link_protect_status_irq_tb
